// ==== rtl/trim_pkg.sv ====
// constants shared by the level-trim serial slave
package trim_pkg;
    localparam logic [6:0] DEV_ADDR      = 7'h4F;
    localparam logic [7:0] NV_FACTORY    = 8'h80;
    localparam int         CLK_HZ        = 10_000_000;
    localparam int         NV_PROG_MS    = 100;
    localparam int         NV_PROG_CYC   = (CLK_HZ / 1000) * NV_PROG_MS;
    localparam int         BYTE_BITS     = 8;
    localparam int         LEVEL_W       = 7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam logic [3:0] BIT_LAST      = 4'h7;
endpackage

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // reset to idle-high so a held bus shows no false edge after release
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_q <= '1;
            sync_o <= '1;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/nv_store.sv ====
// non-volatile level store with program-busy timer
`timescale 1ns/1ps
`default_nettype none
module nv_store
    import trim_pkg::*;
#(
    parameter int PROG_CYC = NV_PROG_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  prog_i,
    input  wire logic [LEVEL_W-1:0]    prog_data_i,
    output logic      [BYTE_BITS-1:0]  stored_o,
    output logic                       busy_o
);
    logic [31:0] cnt_q;

    // contents survive reset: reset stands in for power loss only of the
    // volatile side, so the stored byte is initialised once, at load time
    logic [BYTE_BITS-1:0] store_q = NV_FACTORY;

    always_ff @(posedge clk_i) begin
        if (prog_i && !busy_o) begin
            store_q <= {1'b0, prog_data_i};
        end
    end

    assign stored_o = store_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q  <= '0;
            busy_o <= 1'b0;
        end else if (prog_i && !busy_o) begin
            cnt_q  <= 32'(PROG_CYC);
            busy_o <= 1'b1;
        end else if (busy_o) begin
            cnt_q  <= cnt_q - 32'd1;
            busy_o <= (cnt_q > 32'd1);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/level_trim_slave.sv ====
// two-wire serial slave holding a 7-bit sink-current level
`timescale 1ns/1ps
`default_nettype none
module level_trim_slave
    import trim_pkg::*;
#(
    parameter int PROG_CYC = NV_PROG_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_o,
    input  wire logic                wp_n_i,
    output logic      [LEVEL_W-1:0]  sink_level_o,
    output logic                     nv_busy_o
);
    import trim_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } state_e;

    state_e                 state_q;
    logic [2:0]             pins_s;
    logic                   scl_s;
    logic                   sda_s;
    logic                   wp_s;
    logic                   scl_prev_q;
    logic                   sda_prev_q;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start_det;
    logic                   stop_det;
    logic [3:0]             bit_q;
    logic [BYTE_BITS-1:0]   shift_q;
    logic                   rd_q;
    logic                   drive_low_q;
    logic                   load_done_q;
    logic                   prog_q;
    logic [BYTE_BITS-1:0]   stored;
    logic                   nv_busy;
    logic [LEVEL_W-1:0]     level_q;

    pin_sync #(
        .W(3)
    ) u_sync (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .async_i ({scl_i, sda_i, wp_n_i}),
        .sync_o  (pins_s)
    );

    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign wp_s  = pins_s[0];

    nv_store #(
        .PROG_CYC(PROG_CYC)
    ) u_nv (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .prog_i     (prog_q),
        .prog_data_i(shift_q[BYTE_BITS-1:1]),
        .stored_o   (stored),
        .busy_o     (nv_busy)
    );

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s && !scl_prev_q;
    assign scl_fall  = !scl_s && scl_prev_q;
    // both lines idle-high before a start is what a new transfer needs
    assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_det  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // frame position: eight data bits, then the acknowledge slot
    function automatic logic at_ack_slot(input logic [3:0] cnt);
        return cnt == ACK_SLOT;
    endfunction

    // address byte carries our address in its upper seven bits
    function automatic logic addr_hit(input logic [BYTE_BITS-1:0] b);
        return b[BYTE_BITS-1:1] == DEV_ADDR;
    endfunction

    // open-drain drive for one data bit: pull low only for a zero
    function automatic logic pull_for(input logic b);
        return !b;
    endfunction

    // outgoing bit at position idx, msb first
    // limitation: index wraps at eight; callers stop at the ack slot
    function automatic logic tx_bit(input logic [BYTE_BITS-1:0] b, input logic [3:0] idx);
        return b[BYTE_BITS-1-idx[2:0]];
    endfunction

    // bus events; a start or stop outranks every bit-level event
    logic quiet;
    logic in_rx;
    logic ack_fall;
    logic bit_sample;
    logic addr_done;
    logic addr_take;
    logic wdata_done;
    logic rd_launch;
    logic rbit_end;
    logic rbit_next;

    assign quiet      = !start_det && !stop_det;
    // receive states share the bit shifter
    assign in_rx      = (state_q == ST_ADDR) || (state_q == ST_WDATA);
    assign ack_fall   = scl_fall && at_ack_slot(bit_q);
    assign bit_sample = quiet && in_rx && scl_rise;
    assign addr_done  = quiet && (state_q == ST_ADDR) && ack_fall;
    // writes are refused while the store is still programming
    assign addr_take  = addr_hit(shift_q) && !(!shift_q[0] && nv_busy);
    assign wdata_done = quiet && (state_q == ST_WDATA) && ack_fall;
    // read byte: msb goes out as the address acknowledge ends
    assign rd_launch  = quiet && (state_q == ST_ADDR_ACK) && scl_fall && rd_q;
    // ninth clock of a read byte belongs to the master
    assign rbit_end   = quiet && (state_q == ST_RDATA) && scl_fall && at_ack_slot(bit_q);
    assign rbit_next  = quiet && (state_q == ST_RDATA) && scl_fall && !at_ack_slot(bit_q);

    // transaction state
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
        end else if (start_det) begin
            state_q <= ST_ADDR; // repeated start also lands here
        end else if (stop_det) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_IGNORE: begin
                    // idle and ignored frames wait for the next start
                    state_q <= state_q;
                end
                ST_ADDR: begin
                    if (ack_fall && addr_take) begin
                        state_q <= ST_ADDR_ACK;
                    end else if (ack_fall) begin
                        state_q <= ST_IGNORE;
                    end
                end
                ST_WDATA: begin
                    if (ack_fall) begin
                        state_q <= ST_WDATA_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    // the direction bit chooses which byte follows
                    if (scl_fall && rd_q) begin
                        state_q <= ST_RDATA;
                    end else if (scl_fall) begin
                        state_q <= ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    // one data byte per write; a second is not acknowledged
                    if (scl_fall) begin
                        state_q <= ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    if (rbit_end) begin
                        state_q <= ST_RDATA_ACK;
                    end
                end
                ST_RDATA_ACK: begin
                    // one byte per read regardless of master ack
                    if (scl_rise) begin
                        state_q <= ST_IGNORE;
                    end
                end
            endcase
        end
    end

    // bit position inside the current byte
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bit_q <= '0;
        end else if (start_det) begin
            bit_q <= '0;
        end else if (bit_sample || rbit_next) begin
            bit_q <= bit_q + 4'h1;
        end else if (in_rx && ack_fall && quiet) begin
            bit_q <= '0;
        end else if (rd_launch) begin
            // msb leaves with the acknowledge, so one bit is already out
            bit_q <= 4'h1;
        end
    end

    // receive shifter; loaded with the level byte for a read
    // write data keeps the selector in bit 0
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            shift_q <= '0;
        end else if (bit_sample) begin
            shift_q <= {shift_q[BYTE_BITS-2:0], sda_s};
        end else if (rd_launch) begin
            shift_q <= {level_q, 1'b0};
        end
    end

    // direction bit, kept for the acknowledge slot that follows
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_q <= 1'b0;
        end else if (addr_done) begin
            rd_q <= shift_q[0];
        end
    end

    // data-line pull; changed only after a clock fall, stable while high
    // any start or stop lets go of the line at once
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drive_low_q <= 1'b0;
        end else if (!quiet) begin
            drive_low_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_IGNORE: begin
                    drive_low_q <= 1'b0;
                end
                ST_ADDR: begin
                    // no pull for a foreign address or a refused write
                    if (ack_fall) begin
                        drive_low_q <= addr_take;
                    end
                end
                ST_WDATA: begin
                    if (ack_fall) begin
                        drive_low_q <= 1'b1;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall && rd_q) begin
                        drive_low_q <= pull_for(level_q[LEVEL_W-1]);
                    end else if (scl_fall) begin
                        drive_low_q <= 1'b0;
                    end
                end
                ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        drive_low_q <= 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (rbit_end) begin
                        drive_low_q <= 1'b0; // release for master ack
                    end else if (rbit_next) begin
                        drive_low_q <= pull_for(tx_bit(shift_q, bit_q));
                    end
                end
                ST_RDATA_ACK: begin
                    // master owns the ninth read clock
                    drive_low_q <= 1'b0;
                end
            endcase
        end
    end

    // commits on the ack slot so the byte has been fully received
    logic commit;
    assign commit = wdata_done;

    // protected writes still complete on the bus but change nothing
    logic level_wr;
    logic prog_wr;
    assign level_wr = commit && wp_s && shift_q[0];
    assign prog_wr  = commit && wp_s && !shift_q[0];

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prog_q <= 1'b0;
        end else begin
            prog_q <= prog_wr;
        end
    end

    // level reload stands for power-up recall; store keeps its contents
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            load_done_q <= 1'b0;
            level_q     <= '0;
        end else if (!load_done_q) begin
            load_done_q <= 1'b1;
            level_q     <= stored[LEVEL_W-1:0];
        end else if (level_wr) begin
            level_q <= shift_q[BYTE_BITS-1:1];
        end
    end

    assign sink_level_o = level_q;
    assign nv_busy_o    = nv_busy;
    assign sda_o        = 1'b0;
    assign sda_oe_o     = drive_low_q;
endmodule
`default_nettype wire

// ==== test/trim_props.sv ====
// assertions on the level-trim slave pins
`timescale 1ns/1ps
`default_nettype none
module trim_props #(
    parameter int PROG_CYC = trim_pkg::NV_PROG_CYC
) (
    input wire logic                         clk_i,
    input wire logic                         resetn_i,
    input wire logic                         scl_i,
    input wire logic                         sda_i,
    input wire logic                         sda_o,
    input wire logic                         sda_oe_o,
    input wire logic                         wp_n_i,
    input wire logic [trim_pkg::LEVEL_W-1:0] sink_level_o,
    input wire logic                         nv_busy_o
);
    import trim_pkg::*;
    int busy_cnt_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // cleared in reset so a mid-run reset starts the count fresh
    always_ff @(posedge clk_i) begin
        busy_cnt_q <= (resetn_i && nv_busy_o) ? busy_cnt_q + 1 : 0;
    end
    property p_drain; sda_o == 1'b0; endproperty
    a_drain: assert property (p_drain) else $error("sda_o high");
    property p_rst; $rose(resetn_i) |-> !sda_oe_o && !nv_busy_o && sink_level_o == '0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_low; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_low: assert property (p_low) else $error("sda pull moved in scl high");
    property p_ack; $rose(scl_i) && sda_oe_o |-> sda_oe_o [*3]; endproperty
    a_ack: assert property (p_ack) else $error("sda pull dropped in scl high");
    property p_stop; scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*3]; endproperty
    a_stop: assert property (p_stop) else $error("sda pulled after stop");
    property p_wp; $changed(sink_level_o) && $past(resetn_i, 3) |-> wp_n_i; endproperty
    a_wp: assert property (p_wp) else $error("level changed while protected");
    property p_wp_nv; $rose(nv_busy_o) |-> wp_n_i; endproperty
    a_wp_nv: assert property (p_wp_nv) else $error("store written while protected");
    property p_prog; $fell(nv_busy_o) |-> busy_cnt_q inside {[PROG_CYC-1:PROG_CYC+1]}; endproperty
    a_prog: assert property (p_prog) else $error("program time wrong");
endmodule
`default_nettype wire

// ==== test/bus_master_model.sv ====
// two-wire bus master: drives the clock, pulls data low or releases it
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic st(input int n, input logic c, input logic lo);
        repeat (n) @(negedge clk_i);
        scl_o = c;
        sda_low_o = lo;
    endtask
    // low phase 5 cycles so the slave's late data change lands before the rise
    task automatic bitx(input logic b, output logic s);
        st(2, 1'b0, ~b);
        st(3, 1'b1, ~b);
        @(negedge clk_i);
        s = sda_i;
        st(2, 1'b0, ~b);
    endtask
    // no repeated start: always stop first, bus then idle
    task automatic xact(input logic [7:0] b0, b1, output logic [7:0] r, output logic a0, a1);
        logic [7:0] junk;
        st(2, scl_o, 1'b0);
        st(2, 1'b1, 1'b0);
        st(3, 1'b1, 1'b1);
        st(3, 1'b0, 1'b1);
        for (int i = 7; i >= 0; i--) bitx(b0[i], junk[i]);
        bitx(1'b1, a0);
        for (int i = 7; i >= 0; i--) bitx(b1[i], r[i]);
        bitx(1'b1, a1);
        st(2, 1'b0, 1'b1);
        st(3, 1'b1, 1'b1);
        st(3, 1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// ==== test/level_trim_slave_tb.sv ====
// self-checking bench for the level-trim slave
`timescale 1ns/1ps
`default_nettype none
module level_trim_slave_tb;
    import trim_pkg::*;
    localparam int PROG_CYC = 400;
    logic               clk_i = 1'b0;
    logic               resetn_i = 1'b0;
    logic               wp_n_i = 1'b0;
    logic               scl_i, sda_low, sda_oe_o, sda_o, nv_busy_o, a1, a2;
    logic [LEVEL_W-1:0] sink_level_o;
    logic [7:0]         r;
    int                 bad_count = 0;
    int                 tests_run = 0;
    // pull-up: line reads high once both parties release it
    wire logic          sda_i = ~(sda_low | sda_oe_o);
    always #50 clk_i = ~clk_i;
    level_trim_slave #(.PROG_CYC(PROG_CYC)) u_level_trim_slave (.clk_i(clk_i),
        .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .wp_n_i(wp_n_i), .sink_level_o(sink_level_o), .nv_busy_o(nv_busy_o));
    bus_master_model u_bus_master_model (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i),
        .sda_low_o(sda_low));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xa(input logic [7:0] b0, input logic [7:0] b1);
        u_bus_master_model.xact(b0, b1, r, a1, a2);
    endtask
    task automatic t_power_up();
        chk("level", {1'b0, NV_FACTORY[6:0]}, {1'b0, sink_level_o});
        xa({DEV_ADDR, 1'b1}, 8'hFF);
        chk("addr ack", 8'h00, {7'h00, a1});
        chk("read", {1'b0, NV_FACTORY[6:0]}, {1'b0, r[7:1]});
        $display("power-up done");
    endtask
    task automatic t_volatile();
        logic [6:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 7'h7F : 7'h2A;
            xa({DEV_ADDR, 1'b0}, {v, 1'b1});
            chk("write acks", 8'h00, {6'h00, a1, a2});
            chk("level", {1'b0, v}, {1'b0, sink_level_o});
            xa({DEV_ADDR, 1'b1}, 8'hFF);
            chk("read back", {1'b0, v}, {1'b0, r[7:1]});
        end
        $display("volatile write done");
    endtask
    task automatic t_refused();
        xa({DEV_ADDR ^ 7'h01, 1'b0}, 8'h2B);
        chk("foreign ack", 8'h01, {7'h00, a1});
        xa({DEV_ADDR ^ 7'h40, 1'b1}, 8'hFF);
        chk("foreign read", 8'hFF, r);
        wp_n_i = 1'b0;
        xa({DEV_ADDR, 1'b0}, 8'h23);
        xa({DEV_ADDR, 1'b0}, 8'h22);
        chk("protected ack", 8'h00, {6'h00, a1, a2});
        chk("protected", 8'h2A, {nv_busy_o, sink_level_o});
        wp_n_i = 1'b1;
        $display("refusal done");
    endtask
    task automatic t_program();
        xa({DEV_ADDR, 1'b0}, {7'h33, 1'b0});
        chk("busy", 8'h01, {7'h00, nv_busy_o});
        xa({DEV_ADDR, 1'b0}, {7'h44, 1'b1});
        chk("busy nack", 8'h01, {7'h00, a1});
        for (int i = 0; i < PROG_CYC && nv_busy_o === 1'b1; i++) @(negedge clk_i);
        chk("busy end", 8'h00, {7'h00, nv_busy_o});
        resetn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("reload", 8'h33, {1'b0, sink_level_o});
        $display("program done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        wp_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_power_up();
        t_volatile();
        t_refused();
        t_program();
        test_done();
    end
    initial begin
        #1_000_000;
        bad_count++;
        test_done();
    end
endmodule
bind level_trim_slave trim_props #(.PROG_CYC(PROG_CYC)) u_trim_props (.clk_i(clk_i),
    .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .wp_n_i(wp_n_i), .sink_level_o(sink_level_o), .nv_busy_o(nv_busy_o));
`default_nettype wire
